// [hdl/mgr_readout.sv]
// Magnetometer sample path, comparator and single-byte I2C target
`timescale 1ns/1ns
module mgr_readout (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] adc_code,
  input wire logic adc_valid,
  input wire logic adc_neg,
  input wire logic [7:0] temp_code,
  input wire logic [6:0] bus_addr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic field_detect,
  output logic [7:0] field_value
);
  logic [7:0] sens, offs, filt_k, thr, hyst, tempco, usr_gain, usr_offs;
  logic [7:0] filt_y, field_byte, mag, corr, result;
  logic [15:0] prod, gained, trim;
  logic [3:0] stage;
  logic [7:0] tx_byte;
  logic [7:0] x_in;
  logic scl_d, sda_d, start_c, stop_c, scl_rise, scl_fall;
  mgr_pkg::mgr_state_t state;
  logic [7:0] shreg, reg_ptr;
  logic [3:0] bitcnt;
  logic ptr_set, mem_we, restore;
  logic [7:0] mem_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Sample path: magnitude, correction, filter, atomic publish
  // Sign comes from the front end; magnitude about zero field
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stage <= 4'h0;
      x_in <= 8'h00;
      mag <= 8'h00;
      prod <= 16'h0000;
      corr <= 8'h00;
    end else begin
      stage <= {stage[2:0], adc_valid};
      if (adc_valid) begin
        x_in <= adc_code; // see [RULE1]
      end
      // Offset-binary code folded about mid-scale; a code on the wrong side reads zero
      if (adc_neg) begin
        mag <= (x_in < mgr_pkg::ADC_MID) ? 8'(mgr_pkg::ADC_MID - x_in) : 8'h00; // see [RULE7]
      end else begin
        mag <= (x_in > mgr_pkg::ADC_MID) ? 8'(x_in - mgr_pkg::ADC_MID) : 8'h00; // see [RULE7]
      end
      // Factory gain in percent plus temperature drift term
      prod <= 16'(({8'h00, mag} * 16'(sens + 8'(({8'h00, temp_code} * tempco) >> 8)))
              / 16'(mgr_pkg::SENS_UNITY)); // see [RULE9]
      // Offsets larger than the sample floor at zero instead of wrapping to full scale
      corr <= (gained > trim) ? mgr_pkg::sat8(16'(gained - trim))
              : 8'h00; // see [RULE10] [RULE13]
    end
  end

  always_comb begin
    result = (corr > filt_y) ? 8'(filt_y + ((corr - filt_y) >> filt_k[2:0]))
           : 8'(filt_y - ((filt_y - corr) >> filt_k[2:0])); // see [RULE15]
  end

  // User gain is 1.7 fixed point; both offsets subtract after it
  always_comb begin
    gained = 16'((32'(mgr_pkg::sat8(prod)) * usr_gain) >> 7);
    trim = 16'(offs) + 16'(usr_offs);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      filt_y <= 8'h00;
      field_byte <= 8'h00;
    end else if (stage[3]) begin
      // Publish one stage after the corrected value lands, never mid-pipeline
      // Filter off: pass through directly
      filt_y <= (filt_k == 8'h00) ? corr : result; // see [RULE2] [RULE3]
      field_byte <= (filt_k == 8'h00) ? corr : result; // see [RULE16] [RULE5]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      field_detect <= 1'b0;
      field_value <= 8'h00;
    end else begin
      field_value <= field_byte;
      if (field_byte > thr) begin
        field_detect <= 1'b1; // see [RULE8] [RULE11]
      end else if ((hyst <= thr) && (field_byte < 8'(thr - hyst))) begin
        // Hysteresis at or above the threshold latches the output on
        field_detect <= 1'b0; // see [RULE11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration registers; restore reloads factory values, address untouched
  always_ff @(posedge ref_clk) begin
    if (!rst_b || restore) begin // see [RULE12] [RULE3]
      sens <= mgr_pkg::RST_SENS;
      offs <= mgr_pkg::RST_OFFS;
      filt_k <= mgr_pkg::RST_FILT;
      thr <= mgr_pkg::RST_THR;
      hyst <= mgr_pkg::RST_HYST;
      tempco <= mgr_pkg::RST_TEMPCO;
      usr_gain <= mgr_pkg::RST_USR_GAIN;
      usr_offs <= mgr_pkg::RST_USR_OFFS;
    end else if (mem_we) begin
      case (reg_ptr)
        mgr_pkg::ADDR_SENS: sens <= shreg;
        mgr_pkg::ADDR_OFFS: offs <= shreg;
        mgr_pkg::ADDR_FILT: filt_k <= shreg;
        mgr_pkg::ADDR_THR: thr <= shreg;
        mgr_pkg::ADDR_HYST: hyst <= shreg;
        mgr_pkg::ADDR_TEMPCO: tempco <= shreg;
        mgr_pkg::ADDR_USR_GAIN: usr_gain <= shreg; // see [RULE10]
        mgr_pkg::ADDR_USR_OFFS: usr_offs <= shreg;
        default: ;
      endcase
    end
  end

  assign restore = mem_we && (reg_ptr == mgr_pkg::ADDR_RESTORE)
                   && (shreg == mgr_pkg::RESTORE_CMD); // see [RULE12]

  // Spare locations kept as scratch bytes
  mgr_param_mem u_mem (
    .ref_clk(ref_clk),
    .we(mem_we),
    .waddr(reg_ptr[3:0]),
    .wdata(shreg),
    .raddr(reg_ptr[3:0]),
    .rdata(mem_rdata)
  );

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    case (a)
      mgr_pkg::ADDR_FIELD: read_byte = field_byte; // see [RULE5] [RULE6]
      mgr_pkg::ADDR_TEMP: read_byte = temp_code;
      mgr_pkg::ADDR_SENS: read_byte = sens;
      mgr_pkg::ADDR_OFFS: read_byte = offs;
      mgr_pkg::ADDR_FILT: read_byte = filt_k;
      mgr_pkg::ADDR_THR: read_byte = thr;
      mgr_pkg::ADDR_HYST: read_byte = hyst;
      mgr_pkg::ADDR_TEMPCO: read_byte = tempco;
      mgr_pkg::ADDR_USR_GAIN: read_byte = usr_gain;
      mgr_pkg::ADDR_USR_OFFS: read_byte = usr_offs;
      default: read_byte = mem_rdata;
    endcase
  endfunction : read_byte

  always_comb begin
    tx_byte = read_byte(reg_ptr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C target; pins sampled on ref_clk, far faster than 400 kHz
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end
  assign scl_rise = scl_in && !scl_d;
  assign scl_fall = !scl_in && scl_d;
  assign start_c = scl_in && scl_d && sda_d && !sda_in;
  assign stop_c = scl_in && scl_d && !sda_d && sda_in;
  // Write once the eighth bit is in the shift register, on the falling edge after it
  assign mem_we = (state == mgr_pkg::MGR_DATA) && scl_fall && (bitcnt == 4'h8) && ptr_set;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= mgr_pkg::MGR_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      reg_ptr <= 8'h00;
      ptr_set <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      state <= mgr_pkg::MGR_ADDR; // see [RULE14]
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      state <= mgr_pkg::MGR_IDLE;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      if (scl_rise) begin
        bitcnt <= 4'(bitcnt + 4'h1);
      end
      // Address and data acknowledge bits (AACK, DACK) stay out of the shift register so the R/W bit survives
      if (scl_rise && state != mgr_pkg::MGR_AACK && state != mgr_pkg::MGR_DACK) begin
        shreg <= {shreg[6:0], sda_in};
      end
      case (state)
        mgr_pkg::MGR_IDLE: sda_oe <= 1'b0;
        mgr_pkg::MGR_ADDR: begin
          if (scl_fall && bitcnt == 4'h8) begin
            if (shreg[7:1] == bus_addr) begin
              state <= mgr_pkg::MGR_AACK;
              sda_oe <= 1'b1;
              ptr_set <= 1'b0;
            end else begin
              state <= mgr_pkg::MGR_IDLE;
            end
          end
        end
        mgr_pkg::MGR_AACK, mgr_pkg::MGR_DACK: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            if (shreg[0] & (state == mgr_pkg::MGR_AACK)) begin
              state <= mgr_pkg::MGR_TX;
              shreg <= tx_byte;
              sda_oe <= !tx_byte[7];
            end else begin
              state <= mgr_pkg::MGR_DATA;
              sda_oe <= 1'b0;
            end
          end
        end
        mgr_pkg::MGR_DATA: begin
          if (scl_fall && bitcnt == 4'h8) begin
            // First byte sets the pointer; later bytes write one location
            if (!ptr_set) begin
              reg_ptr <= shreg; // see [RULE4]
              ptr_set <= 1'b1;
            end
            state <= mgr_pkg::MGR_DACK;
            sda_oe <= 1'b1;
          end
        end
        mgr_pkg::MGR_TX: begin
          if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              state <= mgr_pkg::MGR_TACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= !shreg[7];
            end
          end
        end
        mgr_pkg::MGR_TACK: begin
          // Single-byte reads: any further bits are ignored until the next start
          if (scl_rise) begin
            state <= mgr_pkg::MGR_IDLE;
          end
        end
        default: state <= mgr_pkg::MGR_IDLE;
      endcase
    end
  end
endmodule : mgr_readout

// [hdl/mgr_pkg.sv]
// Constants and types shared by the magnetometer readout design
//
// Overview of operation
// [RULE1] Field signal digitised to eight-bit unsigned sample
// [RULE2] Optional first-order low-pass filter, programmable cutoff
// [RULE3] Factory config or restore disables the filter
// [RULE4] Every host value is exactly one byte
// [RULE5] Measurement byte always complete, never stalls reads
// [RULE6] Host may read any time, no setup
// [RULE7] Output is field magnitude, either polarity positive
// [RULE8] Field-detect output follows threshold crossings
// [RULE9] Factory sensitivity, offset, linearity, temperature corrections applied; code has no linearity correction
// [RULE10] User calibration adjusts output atop factory calibration
// [RULE11] Detect high above threshold, low below threshold minus hysteresis
// [RULE12] Writing 1 to location 0x7 restores factory
// [RULE13] Full linear range reads 100, saturation 255
// [RULE14] I2C target up to 400 kHz, host controls
// [RULE15] Filter update y plus (x minus y) shifted k
// [RULE16] Measurement byte updated atomically once per sample
package mgr_pkg;
  // Parameter memory locations, one byte each
  localparam logic [7:0] ADDR_FIELD = 8'h00;
  localparam logic [7:0] ADDR_TEMP = 8'h01;
  localparam logic [7:0] ADDR_SENS = 8'h02;
  localparam logic [7:0] ADDR_OFFS = 8'h03;
  localparam logic [7:0] ADDR_FILT = 8'h04;
  localparam logic [7:0] ADDR_THR = 8'h05;
  localparam logic [7:0] ADDR_HYST = 8'h06;
  localparam logic [7:0] ADDR_RESTORE = 8'h07;
  localparam logic [7:0] ADDR_TEMPCO = 8'h08;
  localparam logic [7:0] ADDR_USR_GAIN = 8'h09;
  localparam logic [7:0] ADDR_USR_OFFS = 8'h0a;
  localparam logic [7:0] RESTORE_CMD = 8'h01;
  localparam int PARAM_WORDS = 16;
  // Factory defaults, then fixed scaling and bus constants
  localparam logic [7:0] RST_SENS = 8'h64;
  localparam logic [7:0] RST_OFFS = 8'h00;
  localparam logic [7:0] RST_FILT = 8'h00;
  localparam logic [7:0] RST_THR = 8'h28;
  localparam logic [7:0] RST_HYST = 8'h05;
  localparam logic [7:0] RST_TEMPCO = 8'h00;
  localparam logic [7:0] RST_USR_GAIN = 8'h80;
  localparam logic [7:0] RST_USR_OFFS = 8'h00;
  localparam logic [7:0] SENS_UNITY = 8'h64;
  localparam logic [7:0] FULL_SCALE = 8'h64;
  localparam logic [7:0] SAT_CODE = 8'hff;
  localparam logic [7:0] ADC_MID = 8'h80;
  localparam logic [7:0] SDA_READ_BIT = 8'h01;
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h10;
  // I2C timing at 125 MHz
  localparam int CLK_MHZ = 125;
  localparam int SCL_MIN_HALF_NS = 1250;
  localparam int SCL_MIN_HALF_CYC = (SCL_MIN_HALF_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    MGR_IDLE = 3'b000,
    MGR_ADDR = 3'b001,
    MGR_AACK = 3'b011,
    MGR_DATA = 3'b010,
    MGR_DACK = 3'b110,
    MGR_TX = 3'b111,
    MGR_TACK = 3'b101
  } mgr_state_t;
  function automatic logic [7:0] sat8(input logic [15:0] v);
    sat8 = (v > 16'h00ff) ? 8'hff : v[7:0];
  endfunction : sat8
endpackage : mgr_pkg

// [hdl/mgr_param_mem.sv]
// Byte-wide parameter memory with registered read port
`timescale 1ns/1ns
module mgr_param_mem (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [3:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [mgr_pkg::PARAM_WORDS];
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : mgr_param_mem

// [verif/mgr_readout_sva.sv]
// Port assertions for the magnetometer readout
`timescale 1ns/1ns
module mgr_readout_sva (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic adc_valid,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic field_detect,
  input wire logic [7:0] field_value
);
  localparam logic [7:0] THR = mgr_pkg::RST_THR;
  localparam logic [7:0] LOW = mgr_pkg::RST_THR - mgr_pkg::RST_HYST;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  AST_ACK_EDGE: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda moved while scl high");
  AST_RESET: assert property (disable iff (1'b0) !rst_b |=>
    field_value == 8'h00 && !field_detect && !sda_oe)
    else $error("outputs not cleared by reset");
  // Either edge count is allowed, a change with no sample behind it is not
  AST_ATOMIC: assert property ($changed(field_value) |->
    $past(adc_valid, 5) || $past(adc_valid, 6))
    else $error("field byte changed without a sample");
  AST_ROSE: assert property ($rose(field_detect) |-> field_value > THR)
    else $error("detect set at or below threshold");
  AST_FELL: assert property ($fell(field_detect) |-> field_value < LOW)
    else $error("detect cleared inside hysteresis");
  AST_HI: assert property ((field_value > THR) [*2] |-> field_detect)
    else $error("detect low above threshold");
  AST_LO: assert property ((field_value < LOW) [*2] |-> !field_detect)
    else $error("detect high below release level");
endmodule : mgr_readout_sva

// [verif/mgr_i2c_host.sv]
// I2C controller model driving the target pins
`timescale 1ns/1ns
module mgr_i2c_host (
  input wire logic ref_clk,
  input wire logic sda_oe,
  output logic scl_in,
  output logic sda_in
);
  localparam int H = mgr_pkg::SCL_MIN_HALF_CYC;
  logic rel = 1'b1;
  logic r;
  logic [7:0] r8;
  initial scl_in = 1'b1;
  // Pull-up wins unless someone pulls low
  assign sda_in = rel & ~sda_oe;
  ////////////////////////////////////////////////////////////////
  task automatic hw;
    repeat (H) @(posedge ref_clk);
  endtask : hw
  task automatic bit_io(input logic b, output logic q);
    rel <= b;
    hw();
    scl_in <= 1'b1;
    hw();
    q = sda_in;
    scl_in <= 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : xfer
  task automatic start;
    rel <= 1'b0;
    hw();
    scl_in <= 1'b0;
    hw();
  endtask : start
  task automatic stop;
    rel <= 1'b0;
    hw();
    scl_in <= 1'b1;
    hw();
    rel <= 1'b1;
    hw();
  endtask : stop
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                    output logic ok);
    logic k1;
    logic k2;
    start();
    xfer({a, 1'b0}, r8, ok);
    xfer(p, r8, k1);
    xfer(d, r8, k2);
    stop();
    ok = ok & k1 & k2;
  endtask : wr
  // Reads straight away, no setup or polling first
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] q,
                    output logic ok);
    logic k1;
    logic k2;
    start();
    xfer({a, 1'b0}, r8, ok);
    xfer(p, r8, k1);
    stop();
    start();
    xfer({a, 1'b1}, r8, k2);
    xfer(8'hff, q, r);
    stop();
    ok = ok & k1 & k2;
  endtask : rd
endmodule : mgr_i2c_host

// [verif/mgr_readout_test.sv]
// Self-checking bench for the magnetometer readout
`timescale 1ns/1ns
module mgr_readout_test;
  typedef struct packed {logic n; logic [7:0] c; logic [7:0] v; logic d;} mgr_row_t;
  // Walks down through the hysteresis band and back above, both polarities
  localparam mgr_row_t ROWS [5] = '{'{1'b0, 8'hb0, 8'h30, 1'b1},
    '{1'b0, 8'ha6, 8'h26, 1'b1}, '{1'b0, 8'ha2, 8'h22, 1'b0},
    '{1'b1, 8'h50, 8'h30, 1'b1}, '{1'b1, 8'h7f, 8'h01, 1'b0}};
  localparam logic [6:0] A = mgr_pkg::BUS_ADDR_DEFAULT;
  logic ref_clk, rst_b, adc_valid, adc_neg, scl_in, sda_in, sda_out, sda_oe;
  logic field_detect, ok;
  logic [7:0] adc_code, temp_code, field_value, q;
  logic [6:0] bus_addr;
  int mismatches = 0;
  int samples_checked = 0;
  mgr_readout u_mgr_readout (.ref_clk(ref_clk), .rst_b(rst_b), .adc_code(adc_code),
    .adc_valid(adc_valid), .adc_neg(adc_neg), .temp_code(temp_code),
    .bus_addr(bus_addr), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .field_detect(field_detect), .field_value(field_value));
  mgr_i2c_host u_mgr_i2c_host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl_in(scl_in),
    .sda_in(sda_in));
  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic smp(input logic n, input logic [7:0] c);
    @(posedge ref_clk);
    adc_neg <= n;
    adc_code <= c;
    adc_valid <= 1'b1;
    @(posedge ref_clk);
    adc_valid <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : smp
  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end
  initial begin
    rst_b = 1'b0;
    adc_code = 8'h80;
    adc_valid = 1'b0;
    adc_neg = 1'b0;
    temp_code = 8'h19;
    bus_addr = A;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk(8'h00, field_value);
    foreach (ROWS[i]) begin
      smp(ROWS[i].n, ROWS[i].c);
      chk(ROWS[i].v, field_value);
      chk({7'h00, ROWS[i].d}, {7'h00, field_detect});
    end
    u_mgr_i2c_host.rd(A, mgr_pkg::ADDR_FIELD, q, ok);
    chk(8'h01, q);
    chk(8'h01, {7'h00, ok});
    u_mgr_i2c_host.wr(A ^ 7'h01, mgr_pkg::ADDR_FILT, 8'h01, ok);
    chk(8'h00, {7'h00, ok});
    u_mgr_i2c_host.wr(A, mgr_pkg::ADDR_FILT, 8'h01, ok);
    chk(8'h01, {7'h00, ok});
    smp(1'b0, 8'hc1);
    chk(8'h21, field_value);
    u_mgr_i2c_host.wr(A, mgr_pkg::ADDR_RESTORE, mgr_pkg::RESTORE_CMD, ok);
    u_mgr_i2c_host.rd(A, mgr_pkg::ADDR_FILT, q, ok);
    chk(mgr_pkg::RST_FILT, q);
    smp(1'b0, 8'h90);
    chk(8'h10, field_value);
    u_mgr_i2c_host.wr(A, mgr_pkg::ADDR_USR_GAIN, 8'h40, ok);
    smp(1'b0, 8'ha0);
    chk(8'h10, field_value);
    rst_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk(8'h00, field_value);
    chk(8'h00, {7'h00, field_detect});
    // Reset must bring the user gain back to unity
    smp(1'b0, 8'ha0);
    chk(8'h20, field_value);
    // An offset above the sample floors the result at zero
    u_mgr_i2c_host.wr(A, mgr_pkg::ADDR_OFFS, 8'h25, ok);
    smp(1'b1, 8'h60);
    chk(8'h00, field_value);
    smp(1'b0, 8'hb0);
    chk(8'h0b, field_value);
    complete_run();
  end
endmodule : mgr_readout_test
bind mgr_readout mgr_readout_sva u_mgr_readout_sva (.ref_clk(ref_clk), .rst_b(rst_b),
  .adc_valid(adc_valid), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .field_detect(field_detect), .field_value(field_value));
